// *** pcw_pkg.sv ***
// Operation
// RQ1 - Load default timeout after every power cycle
// RQ2 - Expiry: power off for interval, restore
// RQ3 - Reload by I2C command or toggle
// RQ4 - Any addressed I2C command reloads countdown
// RQ5 - Period replaced by default after cycle
// RQ6 - Host reloads faster than active period
// RQ7 - Period zero disables the watchdog
// RQ8 - Off interval restored to ten after cycle
// RQ9 - Standby until first I2C access
// RQ10 - First power-up: power off, self-check, restore
// RQ11 - LED five per second on error, else one
// RQ12 - Faster blink last ten seconds; lit while off
// RQ13 - Count power cycles, readable, clearable
// RQ14 - Switch to battery when supply fails
// RQ15 - Cut power when battery below 2.8V
// RQ16 - Host shuts down at 3.0V battery
// RQ17 - Charge status code off/charged/charging/fault
// RQ18 - Voltages readable in millivolts
// RQ19 - Processor temperature readable
// RQ20 - Host picks default longer than boot
// RQ21 - Timed power-down via off interval, short period
// RQ22 - I2C slave at seven-bit address 0x30
// RQ23 - One-second tick decrements active countdown
// RQ24 - Synchronised reload input, any change reloads
package pcw_pkg;
  // ==========================================================
  // Timing, thresholds and address
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_SEC_NS = 1_000_000_000;
  localparam int TICK_CYCLES = int'((64'(TICK_SEC_NS) * CLK_HZ) / 64'd1_000_000_000);
  localparam logic [15:0] DEF_TIMEOUT_S = 16'h0078;
  localparam logic [15:0] DEF_OFF_S = 16'h000A;
  localparam logic [15:0] WARN_S = 16'h000A;
  localparam logic [15:0] BAT_CUT_MV = 16'h0AF0;
  localparam logic [6:0] I2C_ADDR = 7'h30;
  localparam int SLOW_DIV = 2;
  localparam int FAST_DIV = 10;
  localparam int WARN_DIV = 4;
  // ==========================================================
  // Commands and states
  typedef enum logic [3:0] {
    CMD_RELOAD = 4'h0,
    CMD_SET_DEFAULT = 4'h1,
    CMD_SET_PERIOD = 4'h2,
    CMD_CLEAR = 4'h3,
    CMD_SET_OFF = 4'h4,
    CMD_GET_DEFAULT = 4'h5,
    CMD_GET_PERIOD = 4'h6,
    CMD_GET_RESETS = 4'h7,
    CMD_GET_VIN = 4'h8,
    CMD_GET_OFF = 4'h9,
    CMD_GET_VHOST = 4'hA,
    CMD_GET_VBAT = 4'hB,
    CMD_GET_CHARGE = 4'hC,
    CMD_GET_TEMP = 4'hD
  } pcw_cmd_type;
  typedef enum logic [2:0] {
    ST_BOOT_OFF = 3'h0,
    ST_CHECK = 3'h1,
    ST_ERROR = 3'h2,
    ST_STANDBY = 3'h3,
    ST_ACTIVE = 3'h4,
    ST_OFF = 3'h5,
    ST_BAT_CUT = 3'h6
  } pcw_state_type;
endpackage

// *** pcw_tick_if.sv ***
`timescale 1ns/1ps
interface pcw_tick_if;
  logic tick;
  logic led_fast;
  logic led_slow;
  logic led_warn;
  modport src (output tick, output led_fast, output led_slow, output led_warn);
  modport dst (input tick, input led_fast, input led_slow, input led_warn);
endinterface

// *** pcw_tick_gen.sv ***
`timescale 1ns/1ps
module pcw_tick_gen
  import pcw_pkg::*;
#(
  parameter int TICK_N = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  pcw_tick_if.src tk
);
  // ==========================================================
  // Second prescaler and blink phases
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic wrap;
  assign wrap = (cnt_ff == 32'(TICK_N - 1));
  assign nxt_cnt = wrap ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
  assign tk.tick = wrap; // RQ23
  assign tk.led_slow = cnt_ff < 32'(TICK_N / SLOW_DIV); // RQ11
  assign tk.led_fast = ((cnt_ff / 32'(TICK_N / FAST_DIV)) & 32'h1) == 32'h0; // RQ11
  assign tk.led_warn = ((cnt_ff / 32'(TICK_N / WARN_DIV)) & 32'h1) == 32'h0; // RQ12
  always_ff @(posedge mclk) begin
    if (!rst_n) cnt_ff <= 32'h0000_0000;
    else cnt_ff <= nxt_cnt;
  end
  chk_tick_single: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.tick |=> !tk.tick) else $error("tick longer than one cycle"); // RQ23
endmodule

// *** pcw_reload_sync.sv ***
`timescale 1ns/1ps
module pcw_reload_sync
  import pcw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output logic toggled
);
  // ==========================================================
  // Three-stage sync, change counts when stages two and three agree
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic [1:0] fill_ff;
  logic agree;
  logic primed;
  // Reference level is taken from stage two while the stages fill,
  // so a pin that idles high after reset gives no false reload
  assign primed = (fill_ff == 2'h3);
  assign agree = (s2_ff == s3_ff);
  assign toggled = primed && agree && (s3_ff != lvl_ff); // RQ24
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lvl_ff <= 1'b0;
      fill_ff <= 2'h0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (!primed) fill_ff <= fill_ff + 2'h1;
      if (!primed) lvl_ff <= s2_ff;
      else if (agree) lvl_ff <= s3_ff;
    end
  end
  chk_toggle_once: assert property (@(posedge mclk) disable iff (!rst_n)
    toggled |=> !toggled) else $error("toggle seen twice"); // RQ24
endmodule

// *** power_cycle_watchdog.sv ***
`timescale 1ns/1ps
module power_cycle_watchdog
  import pcw_pkg::*;
#(
  parameter int TICK_N = TICK_CYCLES,
  parameter int CHECK_S = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reload_toggle_input,
  input wire logic cmd_valid,
  input wire logic [6:0] cmd_addr,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic supply_ok,
  input wire logic selfcheck_ok,
  input wire logic [15:0] vin_mv,
  input wire logic [15:0] vhost_mv,
  input wire logic [15:0] vbat_mv,
  input wire logic [1:0] charge_code,
  input wire logic [15:0] temp_c,
  input wire logic [31:0] nv_count_in,
  input wire logic nv_ready,
  output logic host_power_en,
  output logic battery_sel,
  output logic led,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic nv_write,
  output logic [31:0] nv_count_out,
  output logic wd_active
);
  // ==========================================================
  // Sub-blocks
  pcw_tick_if tk();
  logic tog;
  pcw_tick_gen #(.TICK_N(TICK_N)) u_tick (.mclk(mclk), .rst_n(rst_n), .tk(tk));
  pcw_reload_sync u_sync (.mclk(mclk), .rst_n(rst_n), .pin(reload_toggle_input),
    .toggled(tog));
  // ==========================================================
  // State
  pcw_state_type st_ff;
  pcw_state_type nxt_st;
  logic [15:0] def_ff;
  logic [15:0] per_ff;
  logic [15:0] off_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [31:0] resets_ff;
  logic loaded_ff;
  logic pwr_ff;
  logic bat_ff;
  logic led_ff;
  logic rv_ff;
  logic [31:0] rd_ff;
  logic nvw_ff;
  logic wa_ff;
  // ==========================================================
  // Decode
  logic hit;
  logic reload;
  logic expire;
  logic off_done;
  logic chk_done;
  logic low_bat;
  logic wr_per;
  logic wr_def;
  logic wr_off;
  logic wr_clr;
  logic cycle_end;
  logic warn;
  logic [31:0] rd_sel;
  assign hit = cmd_valid && (cmd_addr == I2C_ADDR); // RQ22
  assign wr_per = hit && (cmd_code == CMD_SET_PERIOD);
  assign wr_def = hit && (cmd_code == CMD_SET_DEFAULT);
  assign wr_off = hit && (cmd_code == CMD_SET_OFF);
  assign wr_clr = hit && (cmd_code == CMD_CLEAR);
  assign reload = hit || tog; // RQ3 RQ4
  assign low_bat = bat_ff && (vbat_mv < BAT_CUT_MV); // RQ15
  assign expire = (st_ff == ST_ACTIVE) && tk.tick && (per_ff != 16'h0000) && !reload
    && (cnt_ff == 16'h0001); // RQ2 RQ7
  assign off_done = (st_ff == ST_OFF) && tk.tick && (cnt_ff <= 16'h0001);
  assign chk_done = (st_ff == ST_CHECK) && tk.tick && (cnt_ff <= 16'h0001);
  assign cycle_end = off_done; // RQ5 RQ8
  assign warn = (st_ff == ST_ACTIVE) && (per_ff != 16'h0000) && (cnt_ff <= WARN_S);
  always_comb begin
    rd_sel = 32'h0000_0000;
    unique case (cmd_code)
      CMD_GET_DEFAULT: rd_sel = {16'h0000, def_ff};
      CMD_GET_PERIOD: rd_sel = {16'h0000, per_ff};
      CMD_GET_RESETS: rd_sel = resets_ff; // RQ13
      CMD_GET_VIN: rd_sel = {16'h0000, vin_mv}; // RQ18
      CMD_GET_OFF: rd_sel = {16'h0000, off_ff};
      CMD_GET_VHOST: rd_sel = {16'h0000, vhost_mv}; // RQ18
      CMD_GET_VBAT: rd_sel = {16'h0000, vbat_mv}; // RQ18
      CMD_GET_CHARGE: rd_sel = {30'h0000_0000, charge_code}; // RQ17
      CMD_GET_TEMP: rd_sel = {16'h0000, temp_c}; // RQ19
      default: rd_sel = 32'h0000_0000;
    endcase
  end
  // ==========================================================
  // Sequencing
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    unique case (st_ff)
      ST_BOOT_OFF: begin
        nxt_st = ST_CHECK; // RQ10
        nxt_cnt = 16'(CHECK_S);
      end
      ST_CHECK: begin
        if (tk.tick && cnt_ff > 16'h0000) nxt_cnt = cnt_ff - 16'h0001;
        if (chk_done) nxt_st = selfcheck_ok ? ST_STANDBY : ST_ERROR; // RQ10
      end
      ST_ERROR: nxt_st = ST_ERROR;
      ST_STANDBY: begin
        if (hit) begin
          nxt_st = ST_ACTIVE; // RQ9
          nxt_cnt = wr_per ? cmd_data : per_ff;
        end
      end
      ST_ACTIVE: begin
        if (wr_per) nxt_cnt = cmd_data;
        else if (reload) nxt_cnt = per_ff; // RQ3 RQ4
        else if (expire) begin
          nxt_st = ST_OFF; // RQ2
          nxt_cnt = off_ff;
        end else if (tk.tick && per_ff != 16'h0000) nxt_cnt = cnt_ff - 16'h0001; // RQ23
      end
      ST_OFF: begin
        if (tk.tick && cnt_ff > 16'h0000) nxt_cnt = cnt_ff - 16'h0001;
        if (off_done) begin
          nxt_st = ST_ACTIVE; // RQ2
          nxt_cnt = def_ff; // RQ1
        end
      end
      ST_BAT_CUT: if (!bat_ff) nxt_st = ST_ACTIVE;
      default: nxt_st = ST_BOOT_OFF;
    endcase
    if (low_bat && st_ff != ST_BAT_CUT) nxt_st = ST_BAT_CUT; // RQ15
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= ST_BOOT_OFF;
      cnt_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end
  // ==========================================================
  // Settings; off interval and period reload after each cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      def_ff <= DEF_TIMEOUT_S;
      per_ff <= DEF_TIMEOUT_S; // RQ1
      off_ff <= DEF_OFF_S;
    end else begin
      if (wr_def) def_ff <= cmd_data;
      if (cycle_end) per_ff <= def_ff; // RQ5
      else if (wr_per) per_ff <= cmd_data; // RQ7
      if (cycle_end) off_ff <= DEF_OFF_S; // RQ8
      else if (wr_off) off_ff <= cmd_data;
    end
  end
  // ==========================================================
  // Cycle counter: nonvolatile copy captured once storage is ready
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resets_ff <= 32'h0000_0000;
      loaded_ff <= 1'b0;
      nvw_ff <= 1'b0;
    end else begin
      nvw_ff <= 1'b0;
      if (!loaded_ff && nv_ready) begin
        resets_ff <= nv_count_in;
        loaded_ff <= 1'b1;
      end else if (expire) begin
        resets_ff <= resets_ff + 32'h0000_0001; // RQ13
        nvw_ff <= 1'b1;
      end else if (wr_clr) begin
        resets_ff <= 32'h0000_0000; // RQ13
        nvw_ff <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Outputs; battery select follows supply loss directly
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwr_ff <= 1'b0;
      bat_ff <= 1'b0;
      led_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      wa_ff <= 1'b0;
    end else begin
      bat_ff <= !supply_ok; // RQ14
      wa_ff <= (nxt_st == ST_ACTIVE); // RQ9
      pwr_ff <= (nxt_st == ST_STANDBY) || (nxt_st == ST_ACTIVE) || (nxt_st == ST_ERROR);
      rv_ff <= hit;
      if (hit) rd_ff <= rd_sel;
      if (st_ff == ST_ERROR) led_ff <= tk.led_fast; // RQ11
      else if (st_ff == ST_OFF) led_ff <= 1'b1; // RQ12
      else if (warn) led_ff <= tk.led_warn; // RQ12
      else if (st_ff == ST_STANDBY || st_ff == ST_ACTIVE) led_ff <= tk.led_slow; // RQ11
      else led_ff <= 1'b0;
    end
  end
  assign host_power_en = pwr_ff;
  assign battery_sel = bat_ff;
  assign led = led_ff;
  assign rsp_valid = rv_ff;
  assign rsp_data = rd_ff;
  assign nv_write = nvw_ff;
  assign nv_count_out = resets_ff;
  assign wd_active = wa_ff;
  // ==========================================================
  // Checks
  chk_expire_off: assert property (@(posedge mclk) disable iff (!rst_n)
    expire |=> (st_ff == ST_OFF) ##1 !host_power_en) else $error("no power off"); // RQ2
  chk_zero_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (per_ff == 16'h0000) |-> !expire) else $error("expiry while disabled"); // RQ7
  chk_off_restore: assert property (@(posedge mclk) disable iff (!rst_n)
    cycle_end |=> (off_ff == DEF_OFF_S) && (per_ff == $past(def_ff))) else $error("no restore"); // RQ8
  chk_reload_cnt: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff == ST_ACTIVE && reload && !wr_per) |=> cnt_ff == $past(per_ff)) else $error("reload"); // RQ4
  chk_standby_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff == ST_STANDBY && !hit && !low_bat) |=> st_ff == ST_STANDBY) else $error("left standby"); // RQ9
  chk_off_led: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff == ST_OFF) ##1 (st_ff == ST_OFF) |-> led) else $error("led not lit"); // RQ12
  chk_count_inc: assert property (@(posedge mclk) disable iff (!rst_n)
    (expire && loaded_ff) |=> nv_write && resets_ff == $past(resets_ff) + 32'h1) else $error("count"); // RQ13
  chk_bat_cut: assert property (@(posedge mclk) disable iff (!rst_n)
    low_bat |=> ##1 !host_power_en) else $error("battery cut missing"); // RQ15
  chk_tick_dec: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff == ST_ACTIVE && tk.tick && !reload && !expire && per_ff != 16'h0000 && !low_bat)
    |=> cnt_ff == $past(cnt_ff) - 16'h1) else $error("no decrement"); // RQ23
  cov_expire: cover property (@(posedge mclk) expire);
  cov_cycle_end: cover property (@(posedge mclk) cycle_end);
  cov_toggle: cover property (@(posedge mclk) tog && st_ff == ST_ACTIVE);
  cov_error: cover property (@(posedge mclk) st_ff == ST_ERROR);
endmodule

// *** pcw_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host side: decoded command strobe and reload toggle line
module pcw_host_model (
  input wire logic mclk,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  output logic cmd_valid,
  output logic [6:0] cmd_addr,
  output logic [3:0] cmd_code,
  output logic [15:0] cmd_data,
  output logic reload_pin
);
  initial begin
    cmd_valid = 1'b0;
    cmd_addr = 7'h00;
    cmd_code = 4'h0;
    cmd_data = 16'h0000;
    reload_pin = 1'b0;
  end
  // Strobe stands for one edge; the answer is taken one cycle later
  task automatic send(input logic [6:0] a, input logic [3:0] c, input logic [15:0] d,
      output logic got, output logic [31:0] q);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_code <= c;
    cmd_data <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    // Released address and data fields show the inverse so stale values never look valid
    cmd_addr <= ~a;
    cmd_data <= ~d;
    #1;
    got = rsp_valid;
    q = rsp_data;
  endtask
  task automatic toggle();
    @(posedge mclk);
    reload_pin <= ~reload_pin;
  endtask
endmodule

// *** test_power_cycle_watchdog.sv ***
`timescale 1ns/1ps
module test_power_cycle_watchdog;
  import pcw_pkg::*;
  localparam int TK = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b1;
  logic selfcheck_ok = 1'b1;
  logic [15:0] vin_mv = 16'h1388;
  logic [15:0] vhost_mv = 16'h13EC;
  logic [15:0] vbat_mv = 16'h0F3C;
  logic [1:0] charge_code = 2'h0;
  logic [15:0] temp_c = 16'h0019;
  logic [31:0] nv_count_in = 32'h0000_0005;
  logic nv_ready = 1'b1;
  logic cmd_valid, reload_pin, host_power_en, battery_sel, led, rsp_valid, nv_write, wd_active;
  logic [6:0] cmd_addr;
  logic [3:0] cmd_code;
  logic [15:0] cmd_data;
  logic [31:0] rsp_data, nv_count_out, q;
  logic got;
  logic [31:0] last_nv = 32'h0;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int cnt;
  // ==========================================================
  // Design and host
  power_cycle_watchdog #(.TICK_N(TK), .CHECK_S(1)) i_power_cycle_watchdog (
    .mclk(mclk), .rst_n(rst_n), .reload_toggle_input(reload_pin), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_code(cmd_code), .cmd_data(cmd_data), .supply_ok(supply_ok),
    .selfcheck_ok(selfcheck_ok), .vin_mv(vin_mv), .vhost_mv(vhost_mv), .vbat_mv(vbat_mv),
    .charge_code(charge_code), .temp_c(temp_c), .nv_count_in(nv_count_in),
    .nv_ready(nv_ready), .host_power_en(host_power_en), .battery_sel(battery_sel),
    .led(led), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .nv_write(nv_write),
    .nv_count_out(nv_count_out), .wd_active(wd_active));
  pcw_host_model i_pcw_host_model (.mclk(mclk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .reload_pin(reload_pin));
  // ==========================================================
  // Clock, store capture, timeout
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (nv_write === 1'b1) last_nv <= nv_count_out;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [3:0] c, input logic [31:0] e);
    i_pcw_host_model.send(I2C_ADDR, c, 16'h0000, got, q);
    chk({31'h0, got}, 32'h1);
    chk(q, e);
  endtask
  task automatic wr(input logic [3:0] c, input logic [15:0] d);
    i_pcw_host_model.send(I2C_ADDR, c, d, got, q);
    chk({31'h0, got}, 32'h1);
  endtask
  task automatic wait_pw(input logic v, input int n);
    for (int i = 0; i < n && host_power_en !== v; i++) @(posedge mclk);
    #1;
    chk({31'h0, host_power_en}, {31'h0, v});
  endtask
  // Counts rising edges of the LED over n cycles
  task automatic leds(input int n, output int r);
    logic p;
    r = 0;
    p = led;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (led === 1'b1 && p === 1'b0) r = r + 1;
      p = led;
    end
  endtask
  task automatic stop_test();
    $display("tests=%0d bad=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    wait_pw(1'b1, 100);
    chk({31'h0, wd_active}, 32'h0);
    leds(5 * TK, cnt);
    chk({31'h0, cnt >= 4 && cnt <= 6}, 32'h1);
    i_pcw_host_model.send(7'h31, CMD_GET_PERIOD, 16'h0000, got, q);
    chk({31'h0, got}, 32'h0);
    chk({31'h0, wd_active}, 32'h0);
    rd(CMD_GET_DEFAULT, 32'h78);
    chk({31'h0, wd_active}, 32'h1);
    rd(CMD_GET_RESETS, 32'h5);
    rd(CMD_GET_VIN, 32'h1388);
    rd(CMD_GET_VHOST, 32'h13EC);
    rd(CMD_GET_VBAT, 32'h0F3C);
    rd(CMD_GET_TEMP, 32'h19);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      charge_code <= 2'(i);
      rd(CMD_GET_CHARGE, 32'(i));
    end
    wr(CMD_SET_PERIOD, 16'h0005);
    // Reloads come every 3 s against a 5 s period
    repeat (3) begin
      repeat (3 * TK) @(posedge mclk);
      i_pcw_host_model.toggle();
    end
    chk({31'h0, host_power_en}, 32'h1);
    repeat (2) begin
      repeat (3 * TK) @(posedge mclk);
      rd(CMD_GET_TEMP, 32'h19);
    end
    chk({31'h0, host_power_en}, 32'h1);
    wr(CMD_SET_OFF, 16'h0004);
    wait_pw(1'b0, 6 * TK);
    repeat (10) @(posedge mclk);
    chk({31'h0, led}, 32'h1);
    chk(last_nv, 32'h6);
    cnt = 11;
    while (host_power_en !== 1'b1 && cnt < 400) begin
      @(posedge mclk);
      cnt = cnt + 1;
    end
    chk({31'h0, cnt >= 4 * TK - 4 && cnt <= 4 * TK + 4}, 32'h1);
    rd(CMD_GET_PERIOD, 32'h78);
    rd(CMD_GET_OFF, 32'h0A);
    wr(CMD_SET_PERIOD, 16'h0000);
    repeat (20 * TK) @(posedge mclk);
    chk({31'h0, host_power_en}, 32'h1);
    wr(CMD_CLEAR, 16'h0000);
    repeat (2) @(posedge mclk);
    chk(last_nv, 32'h0);
    rd(CMD_GET_RESETS, 32'h0);
    supply_ok <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({31'h0, battery_sel}, 32'h1);
    vbat_mv <= BAT_CUT_MV;
    repeat (5) @(posedge mclk);
    chk({31'h0, host_power_en}, 32'h1);
    vbat_mv <= BAT_CUT_MV - 16'h0001;
    repeat (5) @(posedge mclk);
    chk({31'h0, host_power_en}, 32'h0);
    supply_ok <= 1'b1;
    vbat_mv <= 16'h0F3C;
    repeat (5) @(posedge mclk);
    chk({31'h0, battery_sel}, 32'h0);
    // A failed self-check after a fresh reset gives the fast blink
    selfcheck_ok <= 1'b0;
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3 * TK) @(posedge mclk);
    leds(5 * TK, cnt);
    chk({31'h0, cnt >= 24 && cnt <= 26}, 32'h1);
    stop_test();
  end
endmodule
